// ===== addr_filter_pkg.sv
// constants for the slave address match and glitch filter block
// assumes an apb slave at 125 mhz; one clock, synchronous reset
package addr_filter_pkg;
    // ****************************************************************
    // register map (printed offsets are indices; byte addr = 4*index)
    // ****************************************************************
    localparam logic [3:0]  IDX_PRIMARY   = 4'h4;
    localparam logic [3:0]  IDX_MODE_CTRL = 4'h5;
    localparam logic [3:0]  IDX_FILTER    = 4'h6;
    localparam logic [3:0]  IDX_UPPER     = 4'h7;
    localparam logic [3:0]  IDX_IRQ_STAT  = 4'h8;
    localparam logic [3:0]  IDX_IRQ_EN    = 4'h9;
    localparam logic [3:0]  IDX_IRQ_CLR   = 4'hA;
    localparam logic [3:0]  IDX_LAST_ADDR = 4'hB;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int          BIT_GCALL     = 7;
    localparam int          BIT_WIDE      = 6;
    localparam int          BIT_RANGE     = 3;
    localparam int          FLT_MSB       = 4;
    // ****************************************************************
    // reset values and masks
    // ****************************************************************
    localparam logic [7:0]  MODE_MASK     = 8'hCF;
    localparam logic [7:0]  FILTER_MASK   = 8'h9F;
    localparam logic [7:0]  UPPER_MASK    = 8'hFE;
    localparam logic [7:0]  RESET_REG     = 8'h00;
    localparam logic [6:0]  GCALL_ADDR    = 7'h00;
    localparam logic [4:0]  TEN_BIT_HDR   = 5'h1E;
    // irq status bits
    localparam int          IRQ_PRIMARY   = 0;
    localparam int          IRQ_RANGE     = 1;
    localparam int          IRQ_GCALL     = 2;
    localparam int          IRQ_UPPER     = 3;
endpackage

// ===== glitch_filter.sv
// glitch filter for one bus line
// assumes input synchronous to clk
`timescale 1ns/1ns
module glitch_filter #(
    parameter int W = 5
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // control
    input  wire logic [W-1:0] width,
    // line
    input  wire logic         line_in,
    output logic              line_out
);
    logic [W-1:0] cnt_r;
    logic         held_r;

    // ****************************************************************
    // filter
    // ****************************************************************
    // RULE_07 reject short pulses
    // a change must persist width+1 cycles before it passes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_r  <= '0;
            held_r <= 1'b1;
        end else if (line_in == held_r) begin
            cnt_r <= '0;
        end else if (cnt_r >= width) begin
            held_r <= line_in;
            cnt_r  <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // RULE_08 zero bypasses
    assign line_out = (width == '0) ? line_in : held_r;
endmodule

// ===== addr_receiver.sv
// start detect and calling address shifter
// assumes filtered scl and sda, idle high
`timescale 1ns/1ns
module addr_receiver (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // bus lines
    input  wire logic       scl,
    input  wire logic       sda,
    // result
    output logic [7:0]      addr_byte,
    output logic            addr_valid
);
    logic       scl_d_r;
    logic       sda_d_r;
    logic       busy_r;
    logic [3:0] bits_r;
    logic [7:0] shift_r;

    // ****************************************************************
    // first byte after a start or repeated start
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_d_r    <= 1'b1;
            sda_d_r    <= 1'b1;
            busy_r     <= 1'b0;
            bits_r     <= 4'h0;
            shift_r    <= 8'h00;
            addr_valid <= 1'b0;
            addr_byte  <= 8'h00;
        end else begin
            scl_d_r    <= scl;
            sda_d_r    <= sda;
            addr_valid <= 1'b0;
            if (scl && scl_d_r && sda_d_r && !sda) begin
                busy_r <= 1'b1;
                bits_r <= 4'h0;
            end else if (scl && scl_d_r && !sda_d_r && sda) begin
                busy_r <= 1'b0;
            end else if (busy_r && scl && !scl_d_r) begin
                shift_r <= {shift_r[6:0], sda};
                bits_r  <= bits_r + 4'h1;
                if (bits_r == 4'h7) begin
                    busy_r     <= 1'b0;
                    addr_valid <= 1'b1;
                    addr_byte  <= {shift_r[6:0], sda};
                end
            end
        end
    end
endmodule

// ===== addr_match_filter.sv
// slave address match and input glitch filter, apb register slave
// assumes scl/sda inputs synchronous to clk, apb master on clk
//
// What this block does
// RULE_01: general call address matches only while general call enable is set; a primary address of zero, the reset value, also matches it in 7-bit mode.
// RULE_02: address width select picks 7-bit (0) or 10-bit (1) slave matching.
// RULE_03: reserved bits of mode, filter and upper-bound registers read zero.
// RULE_04: with range enable, addresses above primary and up to upper bound match.
// RULE_05: with range disabled, the in-between addresses do not match by range.
// RULE_06: mode bits 2-0 are address bits 10:8, used only in 10-bit mode.
// RULE_07: pulses no wider than the filter setting in clocks are blocked.
// RULE_08: filter setting zero bypasses, n suppresses glitches up to n clocks.
// RULE_09: upper-bound bits 7-1 are a second 7-bit address and the range top.
// RULE_10: the upper-bound register stays disabled until a nonzero write.
// RULE_11: any address match sets the pending interrupt flag.
// RULE_12: the same filter sits on both scl and sda ahead of decoding.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module addr_match_filter (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [5:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // i2c lines
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    // status
    output logic             addr_match,
    output logic             pending_interrupt_flag,
    output logic             irq
);
    logic [7:0] primary_slave_address_reg;
    logic [7:0] address_mode_control;
    logic [7:0] input_glitch_filter;
    logic [7:0] upper_bound_slave_addr;
    logic       upper_active_r;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_en_r;
    logic [7:0] last_addr_r;
    logic       hdr_seen_r;
    logic       scl_f;
    logic       sda_f;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic [3:0] hit;
    logic [3:0] idx;
    logic       wr_en;
    logic       rd_en;

    function automatic logic known_idx(input logic [3:0] i);
        known_idx = (i >= addr_filter_pkg::IDX_PRIMARY) && (i <= addr_filter_pkg::IDX_LAST_ADDR);
    endfunction

    assign idx   = paddr[5:2];
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;

    // ****************************************************************
    // filters and address capture
    // ****************************************************************
    // RULE_12 one filter per line
    glitch_filter #(.W(5)) u_flt_scl (
        .clk      (clk),
        .reset_n  (reset_n),
        .width    (input_glitch_filter[addr_filter_pkg::FLT_MSB:0]),
        .line_in  (scl_in),
        .line_out (scl_f)
    );
    glitch_filter #(.W(5)) u_flt_sda (
        .clk      (clk),
        .reset_n  (reset_n),
        .width    (input_glitch_filter[addr_filter_pkg::FLT_MSB:0]),
        .line_in  (sda_in),
        .line_out (sda_f)
    );
    addr_receiver u_rx (
        .clk        (clk),
        .reset_n    (reset_n),
        .scl        (scl_f),
        .sda        (sda_f),
        .addr_byte  (rx_byte),
        .addr_valid (rx_valid)
    );

    // ****************************************************************
    // match decode
    // ****************************************************************
    // 10-bit: header bits 11110 a10 a9 compared, r/w ignored; low byte not decoded here
    always_comb begin
        hit = 4'h0;
        if (address_mode_control[addr_filter_pkg::BIT_WIDE]) begin
            // RULE_02 ten bit scheme
            // RULE_06 upper bits used
            hit[addr_filter_pkg::IRQ_PRIMARY] =
                (rx_byte[7:3] == addr_filter_pkg::TEN_BIT_HDR) &&
                (rx_byte[2:1] == address_mode_control[2:1]);
        end else begin
            hit[addr_filter_pkg::IRQ_PRIMARY] =
                (rx_byte[7:1] == primary_slave_address_reg[7:1]);
        end
        // RULE_01 general call gate
        hit[addr_filter_pkg::IRQ_GCALL] =
            address_mode_control[addr_filter_pkg::BIT_GCALL] &&
            (rx_byte[7:1] == addr_filter_pkg::GCALL_ADDR);
        // RULE_09 second address
        // RULE_10 gated until written
        hit[addr_filter_pkg::IRQ_UPPER] = upper_active_r &&
            !address_mode_control[addr_filter_pkg::BIT_WIDE] &&
            (rx_byte[7:1] == upper_bound_slave_addr[7:1]);
        // RULE_04 range window
        // RULE_05 only when enabled
        hit[addr_filter_pkg::IRQ_RANGE] = upper_active_r &&
            address_mode_control[addr_filter_pkg::BIT_RANGE] &&
            !address_mode_control[addr_filter_pkg::BIT_WIDE] &&
            (rx_byte[7:1] > primary_slave_address_reg[7:1]) &&
            (rx_byte[7:1] <= upper_bound_slave_addr[7:1]);
    end

    // ****************************************************************
    // register writes
    // ****************************************************************
    // RULE_03 reserved bits masked
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            primary_slave_address_reg <= addr_filter_pkg::RESET_REG;
            address_mode_control      <= addr_filter_pkg::RESET_REG;
            input_glitch_filter       <= addr_filter_pkg::RESET_REG;
            upper_bound_slave_addr    <= addr_filter_pkg::RESET_REG;
            irq_en_r                  <= 4'h0;
        end else if (wr_en) begin
            case (idx)
                addr_filter_pkg::IDX_PRIMARY:
                    primary_slave_address_reg <= {pwdata[7:1], 1'b0};
                addr_filter_pkg::IDX_MODE_CTRL:
                    address_mode_control <= pwdata[7:0] & addr_filter_pkg::MODE_MASK;
                addr_filter_pkg::IDX_FILTER:
                    input_glitch_filter <= pwdata[7:0] & addr_filter_pkg::FILTER_MASK;
                addr_filter_pkg::IDX_UPPER:
                    upper_bound_slave_addr <= pwdata[7:0] & addr_filter_pkg::UPPER_MASK;
                addr_filter_pkg::IDX_IRQ_EN:
                    irq_en_r <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // RULE_10 nonzero write enables
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            upper_active_r <= 1'b0;
        end else if (wr_en && idx == addr_filter_pkg::IDX_UPPER) begin
            upper_active_r <= (pwdata[7:1] != 7'h00);
        end
    end

    // ****************************************************************
    // events and interrupt
    // ****************************************************************
    // RULE_11 match sets flag
    // set wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_stat_r             <= 4'h0;
            pending_interrupt_flag <= 1'b0;
            addr_match             <= 1'b0;
            last_addr_r            <= 8'h00;
            hdr_seen_r             <= 1'b0;
            irq                    <= 1'b0;
        end else begin
            addr_match <= rx_valid && (hit != 4'h0);
            if (rx_valid) begin
                last_addr_r <= rx_byte;
                hdr_seen_r  <= hit[addr_filter_pkg::IRQ_PRIMARY];
            end
            if (wr_en && idx == addr_filter_pkg::IDX_IRQ_CLR) begin
                irq_stat_r <= (irq_stat_r & ~pwdata[3:0]) | (rx_valid ? hit : 4'h0);
            end else if (rx_valid) begin
                irq_stat_r <= irq_stat_r | hit;
            end
            pending_interrupt_flag <= (irq_stat_r != 4'h0);
            irq                    <= ((irq_stat_r & irq_en_r) != 4'h0);
        end
    end

    // ****************************************************************
    // apb read and handshake
    // ****************************************************************
    // one wait-free access; unmapped offsets answer pslverr and zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !known_idx(idx);
            if (rd_en) begin
                case (idx)
                    addr_filter_pkg::IDX_PRIMARY:
                        prdata <= {24'h00_0000, primary_slave_address_reg};
                    addr_filter_pkg::IDX_MODE_CTRL:
                        prdata <= {24'h00_0000, address_mode_control};
                    addr_filter_pkg::IDX_FILTER:
                        prdata <= {24'h00_0000, input_glitch_filter};
                    addr_filter_pkg::IDX_UPPER:
                        prdata <= {24'h00_0000, upper_bound_slave_addr};
                    addr_filter_pkg::IDX_IRQ_STAT:
                        prdata <= {28'h000_0000, irq_stat_r};
                    addr_filter_pkg::IDX_IRQ_EN:
                        prdata <= {28'h000_0000, irq_en_r};
                    addr_filter_pkg::IDX_LAST_ADDR:
                        prdata <= {23'h00_0000, hdr_seen_r, last_addr_r};
                    default:
                        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// ===== addr_match_props.sv
// checker: apb answer, reserved bits, match and interrupt outputs
// assumes binding to addr_match_filter, one clock domain
`timescale 1ns/1ns
module addr_match_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [5:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // status
    input wire logic        addr_match,
    input wire logic        pending_interrupt_flag,
    input wire logic        irq
);
    // ****
    // properties
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_setup; psel && !penable; endsequence
    sequence s_rd(idx); pready && !pwrite && paddr[5:2] == idx; endsequence
    property p_ready; s_setup |=> pready && penable; endproperty
    a_ready: assert property (p_ready) else $error("late apb answer");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_err; pready |-> pslverr == (paddr[5:2] < 4'h4 || paddr[5:2] > 4'hB); endproperty
    a_err: assert property (p_err) else $error("bad error answer");
    property p_mode; s_rd(4'h5) |-> prdata[5:4] == 2'b00 && prdata[31:8] == 24'h00_0000; endproperty
    a_mode: assert property (p_mode) else $error("mode reserved set");
    property p_flt; s_rd(4'h6) |-> prdata[6:5] == 2'b00; endproperty
    a_flt: assert property (p_flt) else $error("filter reserved set");
    property p_upr; s_rd(4'h7) |-> prdata[0] == 1'b0; endproperty
    a_upr: assert property (p_upr) else $error("upper reserved set");
    property p_pend; addr_match |-> ##[1:2] pending_interrupt_flag; endproperty
    a_pend: assert property (p_pend) else $error("match without flag");
    property p_irq; irq |-> pending_interrupt_flag; endproperty
    a_irq: assert property (p_irq) else $error("irq without flag");
    property p_once; addr_match |=> !addr_match; endproperty
    a_once: assert property (p_once) else $error("match not a pulse");
endmodule

bind addr_match_filter addr_match_props u_props (.clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .addr_match, .pending_interrupt_flag, .irq);

// ===== i2c_caller.sv
// partner: i2c master sending start, one calling byte, ack slot, stop
// assumes pull-ups keep both lines high while idle
`timescale 1ns/1ns
module i2c_caller (
    // clock
    input wire logic       clk,
    // request
    input wire logic       go,
    input wire logic [7:0] call_byte,
    input wire logic [5:0] glitch,
    // bus lines
    output logic           scl,
    output logic           sda,
    output logic           busy
);
    // half bit; above the widest filter setting
    localparam int HALF = 40;
    logic [8:0] sh;
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                sh = {call_byte, 1'b0};
                busy <= 1'b1;
                sda <= 1'b0;
                hold(HALF);
                for (int i = 8; i >= 0; i--) begin
                    scl <= 1'b0;
                    hold(HALF / 2);
                    sda <= sh[i];
                    hold(HALF / 2);
                    scl <= 1'b1;
                    hold(HALF);
                    // low pulse on scl in the fourth bit
                    if (i == 5 && glitch != 6'h00) begin
                        scl <= 1'b0;
                        hold(int'(glitch));
                        scl <= 1'b1;
                        hold(HALF);
                    end
                end
                sda <= 1'b1;
                hold(HALF);
                busy <= 1'b0;
            end
        end
    end
endmodule

// ===== addr_match_filter_bench.sv
// bench: register access, calling addresses, glitch filter, interrupts
// assumes addr_match_props bound and i2c_caller on the bus lines
`timescale 1ns/1ns
module addr_match_filter_bench;
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic        addr_match, pend, irq, scl, sda, go, busy, e, upr_on;
    logic [5:0]  paddr, glitch, fl;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  call_byte, hits, mode;
    logic [6:0]  prim, upr, a;
    int          miscompares, total_checks, n;
    addr_match_filter dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .scl_in(scl), .sda_in(sda), .addr_match,
        .pending_interrupt_flag(pend), .irq);
    i2c_caller master (.clk, .go, .call_byte, .glitch, .scl, .sda, .busy);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // one owner for the match counter; cleared while reset is held
    always @(posedge clk) begin
        if (reset_n !== 1'b1) begin
            hits <= 8'h00;
        end else if (addr_match === 1'b1) begin
            hits <= hits + 8'h01;
        end
    end
    // ****
    // tasks
    // ****
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic hang;
        miscompares++;
        $display("wrong value wait expected done seen timeout");
        end_of_test;
    endtask
    task automatic apb(input logic w, input logic [3:0] i, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) hang;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic xfer(input logic [6:0] x, input logic [5:0] g, input logic m);
        logic [7:0] h0;
        h0 = hits;
        call_byte <= {x, 1'($urandom)};
        glitch <= g;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        for (n = 0; busy === 1'b1 && n < 3000; n++) @(posedge clk);
        if (busy !== 1'b0) hang;
        repeat (2) @(posedge clk);
        chk("match", {31'h0000_0000, m}, {24'h00_0000, hits - h0});
    endtask
    function automatic logic exp_match(input logic [6:0] x);
        if (mode[7] && x == 7'h00) return 1'b1;
        if (mode[6]) return x[6:2] == 5'h1E && x[1:0] == mode[2:1];
        return x == prim || (upr_on && (x == upr || (mode[3] && x > prim && x <= upr)));
    endfunction
    // ****
    // sequence
    // ****
    initial begin
        {reset_n, psel, penable, pwrite, go, upr_on, paddr, pwdata} = '0;
        {call_byte, glitch, miscompares, total_checks} = '0;
        void'($urandom(17964));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 5; i < 8; i++) begin
            apb(1'b0, 4'(i), 32'h0000_0000);
            chk("reset", 32'h0000_0000, q);
            apb(1'b1, 4'(i), 32'hFFFF_FFFF);
            apb(1'b0, 4'(i), 32'h0000_0000);
            chk("mask", {24'h00_0000, i == 5 ? addr_filter_pkg::MODE_MASK : i == 6 ?
                addr_filter_pkg::FILTER_MASK : addr_filter_pkg::UPPER_MASK}, q);
            apb(1'b1, 4'(i), 32'h0000_0000);
        end
        apb(1'b0, 4'h2, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0000_0000, e});
        $display("test registers done");
        // alternating bits, so a doubled bit changes the byte
        prim = 7'h2A;
        mode = 8'h00;
        apb(1'b1, 4'h4, {24'h00_0000, prim, 1'b0});
        for (int k = 0; k < 3; k++) begin
            fl = k == 0 ? 6'h00 : k == 1 ? 6'(1 + $urandom % 30) : 6'h1F;
            apb(1'b1, 4'h6, {26'h000_0000, fl});
            xfer(prim, fl, 1'b1);
            xfer(prim, fl + 6'h01, 1'b0);
        end
        $display("test filter done");
        mode = 8'h08;
        apb(1'b1, 4'h5, {24'h00_0000, mode});
        xfer(prim + 7'h01, 6'h00, 1'b0);
        upr = prim + 7'(1 + $urandom % 8);
        apb(1'b1, 4'h7, {24'h00_0000, upr, 1'b0});
        upr_on = 1'b1;
        for (int m = 0; m < 6; m++) begin
            mode = m < 4 ? {m[1], 3'b000, m[0], 3'b000} : {m[0], 4'b1000, 3'($urandom)};
            apb(1'b1, 4'h5, {24'h00_0000, mode});
            for (int j = 0; j < 7; j++) begin
                a = j == 0 ? 7'h00 : j == 1 ? prim : j == 2 ? prim + 7'h01 : j == 3 ? upr :
                    j == 4 ? upr + 7'h01 : j == 5 ? {5'h1E, mode[2:1]} : 7'($urandom);
                xfer(a, 6'h00, exp_match(a));
            end
        end
        $display("test matching done");
        apb(1'b1, 4'h5, 32'h0000_0000);
        apb(1'b1, 4'hA, 32'h0000_000F);
        apb(1'b1, 4'h9, 32'h0000_0001);
        xfer(prim, 6'h00, 1'b1);
        chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
        apb(1'b0, 4'h8, 32'h0000_0000);
        chk("status", 32'h0000_0001, q);
        apb(1'b1, 4'h9, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk("masked", 32'h0000_0001, {30'h0000_0000, irq, pend});
        apb(1'b1, 4'hA, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("cleared", 32'h0000_0000, {31'h0000_0000, pend});
        // general call, then the top address: upper and range sources together
        mode = 8'h88;
        apb(1'b1, 4'h5, {24'h00_0000, mode});
        xfer(7'h00, 6'h00, 1'b1);
        xfer(upr, 6'h00, 1'b1);
        apb(1'b0, 4'h8, 32'h0000_0000);
        chk("sources", 32'((1 << addr_filter_pkg::IRQ_GCALL) |
            (1 << addr_filter_pkg::IRQ_UPPER) | (1 << addr_filter_pkg::IRQ_RANGE)), q);
        apb(1'b0, 4'hB, 32'h0000_0000);
        chk("last address", {24'h00_0000, call_byte}, q);
        $display("test interrupt done");
        end_of_test;
    end
endmodule
